// >>> dv/asu_partner.sv
`timescale 1ns/1ps
module asu_partner (
    // Clock
    input wire logic clk_in,
    // Wire from the device, line into it
    input wire logic line_in,
    output logic line_out
);
    int bit_cyc = 16;
    int nbits = 10;
    logic [12:0] cap;
    logic [12:0] got_q[$];
    initial line_out = 1'h1;
    // Mid-cell sampling; cells past the frame read high
    always begin
        @(posedge clk_in);
        if (line_in === 1'h0) begin
            cap = 13'h1fff;
            repeat (bit_cyc / 2 - 1) @(posedge clk_in);
            for (int k = 0; k < nbits; k++) begin
                cap[k] = line_in;
                repeat (bit_cyc) @(posedge clk_in);
            end
            got_q.push_back(cap);
        end
    end
    // Stop cells leave the line high, as its pull-up would
    task automatic send(input logic [12:0] f);
        for (int k = 0; k < nbits; k++) begin
            @(negedge clk_in);
            line_out = f[k];
            repeat (bit_cyc - 1) @(negedge clk_in);
        end
    endtask
endmodule // asu_partner

// >>> dv/asu_uart_monitor.sv
`timescale 1ns/1ps
module asu_uart_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Controls
    input wire logic tx_enable_in,
    input wire logic tx_irq_source_select_in,
    input wire logic open_drain_select_in,
    input wire logic tx_pin_route_in,
    // Status and pins
    input wire logic tx_buffer_empty_out,
    input wire logic shifter_empty_flag_out,
    input wire logic tx_irq_out,
    input wire logic rx_complete_out,
    input wire logic rx_irq_out,
    input wire logic serial_out_pin_out,
    input wire logic serial_out_pin_oe_out
);
    // Pull-up holds the wire high when undriven
    wire logic line_lvl;
    assign line_lvl = serial_out_pin_oe_out ? serial_out_pin_out : 1'h1;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_ROUTE_OFF: assert property (
        !tx_pin_route_in && !$past(tx_pin_route_in) |-> !serial_out_pin_oe_out)
        else $error("pin driven while unrouted");
    AST_IDLE_HIGH: assert property (shifter_empty_flag_out |-> line_lvl)
        else $error("idle wire low");
    AST_OD_LOW: assert property (
        open_drain_select_in && $past(open_drain_select_in) && serial_out_pin_oe_out
        |-> !serial_out_pin_out) else $error("open drain drove high");
    AST_LOAD_START: assert property (
        $rose(tx_buffer_empty_out) |-> !shifter_empty_flag_out && !line_lvl)
        else $error("load without start bit");
    AST_IRQ_LOAD: assert property (
        $rose(tx_buffer_empty_out) && !tx_irq_source_select_in |-> ##[0:1] tx_irq_out)
        else $error("no irq at load");
    AST_IRQ_END: assert property (
        $rose(shifter_empty_flag_out) && tx_irq_source_select_in |-> tx_irq_out)
        else $error("no irq at shift end");
    AST_TX_HOLD: assert property (
        !tx_enable_in && shifter_empty_flag_out |=> shifter_empty_flag_out)
        else $error("load while disabled");
    AST_IRQ_PULSE: assert property (tx_irq_out |=> !tx_irq_out)
        else $error("tx irq too long");
    AST_RX_IRQ: assert property ($rose(rx_complete_out) |-> rx_irq_out)
        else $error("no rx irq");
    COV_TX_END: cover property ($rose(shifter_empty_flag_out));
    COV_RX_DONE: cover property ($rose(rx_complete_out));
    COV_OD: cover property (open_drain_select_in && serial_out_pin_oe_out);
endmodule // asu_uart_monitor

bind asu_uart asu_uart_monitor u_asu_uart_monitor (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .tx_enable_in(tx_enable_in), .tx_irq_source_select_in(tx_irq_source_select_in),
    .open_drain_select_in(open_drain_select_in), .tx_pin_route_in(tx_pin_route_in),
    .tx_buffer_empty_out(tx_buffer_empty_out), .shifter_empty_flag_out(shifter_empty_flag_out),
    .tx_irq_out(tx_irq_out), .rx_complete_out(rx_complete_out), .rx_irq_out(rx_irq_out),
    .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_out(serial_out_pin_oe_out));

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'h0;
    logic rst_n = 1'h0;
    logic [2:0] mode = asu_pkg::MODE_OFF;
    logic stp = 1'h0, pev = 1'h0, pen = 1'h0, msb = 1'h0, ckx = 1'h0, fc = 1'h0;
    logic txe = 1'h0, rxe = 1'h0, irs = 1'h0, od = 1'h0, txr = 1'h1, rxr = 1'h1;
    logic ckr = 1'h1, wr = 1'h0, rd = 1'h0, ext = 1'h0;
    logic [1:0] src = 2'h0;
    logic [7:0] ndiv = 8'h00;
    logic [8:0] txd = 9'h000, rxdat, d;
    logic tbe, sfe, txq, rxc, ovr, perr, rxq, sout, soe, sin;
    wire logic line = soe ? sout : 1'h1;
    int seed = 95388;
    int num_errors = 0, compares = 0, txi = 0, rxi = 0, len = 7, nb = 9, cyc = 16;

    asu_uart u_asu_uart (.clk_in(clk_in), .rst_n_in(rst_n), .serial_mode_field_in(mode),
        .stop_length_select_in(stp), .parity_odd_even_in(pev), .parity_enable_in(pen),
        .bit_order_select_in(msb), .clock_source_select_in(ckx),
        .count_source_field_in(src), .baud_divider_in(ndiv), .fc_clock_in(fc),
        .tx_enable_in(txe), .rx_enable_in(rxe), .tx_irq_source_select_in(irs),
        .open_drain_select_in(od), .tx_pin_route_in(txr), .rx_pin_route_in(rxr),
        .clock_pin_route_in(ckr), .tx_data_in(txd), .tx_write_in(wr),
        .tx_buffer_empty_out(tbe), .shifter_empty_flag_out(sfe), .tx_irq_out(txq),
        .rx_read_in(rd), .rx_data_out(rxdat), .rx_complete_out(rxc),
        .overrun_flag_out(ovr), .parity_fault_flag_out(perr), .rx_irq_out(rxq),
        .serial_in_pin_in(sin), .ext_clock_pin_in(ext), .serial_out_pin_out(sout),
        .serial_out_pin_oe_out(soe));
    asu_partner u_asu_partner (.clk_in(clk_in), .line_in(line), .line_out(sin));

    always #50 clk_in = ~clk_in;
    always #200 fc = ~fc;
    always #300 ext = ~ext;
    always @(posedge clk_in) begin
        txi <= txi + int'(txq === 1'h1);
        rxi <= rxi + int'(rxq === 1'h1);
    end

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_for(input logic rx, input logic lvl);
        for (int t = 0; (rx ? rxc : sfe) !== lvl; t++) begin
            if (t > 30000) begin
                check(13'h0, 13'h1);
                end_of_test;
            end
            @(negedge clk_in);
        end
    endtask

    // Model frame: start low, data, parity, stops high
    function automatic logic [12:0] frame(input logic [8:0] v, input logic flip);
        logic [12:0] f;
        logic p;
        f = 13'h1ffe;
        p = ~pev;
        for (int k = 0; k < len; k++) begin
            f[k + 1] = msb ? v[len - 1 - k] : v[k];
            p ^= v[k];
        end
        if (pen)
            f[len + 1] = p ^ flip;
        return f;
    endfunction

    task automatic set_cfg(input int i);
        @(negedge clk_in);
        txe = 1'h0;
        rxe = 1'h0;
        @(negedge clk_in);
        mode = asu_pkg::MODE_OFF;
        len = 7 + i % 3;
        pen = i[1];
        pev = i[2];
        stp = i[3];
        msb = len == 8 && i[0];
        irs = i[0];
        od = i == 5;
        src = 2'(i % 5);
        ckx = i % 5 == 4;
        ndiv = 8'(i % 2);
        nb = len + 2 + pen + stp;
        cyc = 16 * (i % 2 + 1) * (ckx ? 6 : src == 0 ? 1 : src == 1 ? 8 : src == 2 ? 32 : 4);
        u_asu_partner.bit_cyc = cyc;
        u_asu_partner.nbits = nb;
        u_asu_partner.got_q.delete();
        txi = 0;
        rxi = 0;
        @(negedge clk_in);
        mode = asu_pkg::MODE_UART7 + 3'(i % 3);
        @(negedge clk_in);
        txe = 1'h1;
        rxe = 1'h1;
    endtask

    task automatic tx_check(input logic [8:0] v, input logic load);
        if (load) begin
            @(negedge clk_in);
            txd = v;
            wr = 1'h1;
            @(negedge clk_in);
            wr = 1'h0;
        end
        wait_for(1'h0, 1'h0);
        wait_for(1'h0, 1'h1);
        repeat (cyc) @(negedge clk_in);
        check(13'(u_asu_partner.got_q.size()), 13'h1);
        if (u_asu_partner.got_q.size() > 0)
            check(u_asu_partner.got_q.pop_front(), frame(v, 1'h0));
        check(13'(txi), 13'h1);
    endtask

    task automatic rx_frame(input logic [8:0] v, input logic flip);
        u_asu_partner.send(frame(v, flip));
        wait_for(1'h1, 1'h1);
        repeat (2) @(negedge clk_in);
    endtask

    task automatic read_rx;
        @(negedge clk_in);
        rd = 1'h1;
        @(negedge clk_in);
        rd = 1'h0;
    endtask

    initial begin
        repeat (4) @(negedge clk_in);
        rst_n = 1'h1;
        check({tbe, sfe, rxc, ovr, perr, txq, rxq}, 13'h60);
        for (int i = 0; i < 10; i++) begin
            set_cfg(i);
            tx_check(9'($random(seed)), 1'h1);
            d = 9'($random(seed));
            rx_frame(d, 1'h0);
            check(rxdat & (9'h1ff >> (9 - len)), d & (9'h1ff >> (9 - len)));
            check({perr, ovr, 2'(rxi)}, 13'h1);
            read_rx;
            check(rxc, 13'h0);
        end
        // Buffered data waits for enable; the unrouted pin stays released
        set_cfg(10);
        @(negedge clk_in);
        txe = 1'h0;
        txr = 1'h0;
        txd = 9'h0a5;
        wr = 1'h1;
        @(negedge clk_in);
        wr = 1'h0;
        repeat (cyc) @(negedge clk_in);
        check({sfe, tbe}, 13'h2);
        check({soe, line}, 13'h1);
        txr = 1'h1;
        txe = 1'h1;
        tx_check(9'h0a5, 1'h0);
        rx_frame(9'h0c3, 1'h1);
        check(perr, 13'h1);
        read_rx;
        check({perr, rxc}, 13'h0);
        u_asu_partner.send(frame(9'h011, 1'h0));
        u_asu_partner.send(frame(9'h122, 1'h0));
        repeat (cyc) @(negedge clk_in);
        check(ovr, 13'h1);
        set_cfg(10);
        check(ovr, 13'h0);
        read_rx;
        rx_frame(9'h05a, 1'h0);
        check(rxdat[7:0], 13'h5a);
        check(ovr, 13'h0);
        end_of_test;
    end
endmodule // testbench

// >>> src/asu_baud_gen.sv
`timescale 1ns/1ps
module asu_baud_gen #(
    parameter int F8_DIV = asu_pkg::PRESCALE_F8,
    parameter int F32_DIV = asu_pkg::PRESCALE_F32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Configuration
    input wire logic clock_source_select_in,
    input wire logic clock_pin_route_in,
    input wire logic [1:0] count_source_field_in,
    input wire logic [7:0] baud_divider_in,
    // Outside clocks
    input wire logic ext_clock_pin_in,
    input wire logic fc_clock_in,
    // Sixteen-times bit rate tick
    output logic tick16_out
);
    generate
        if (F8_DIV < 2 || F32_DIV < 2 || F8_DIV > 256 || F32_DIV > 256) begin : g_bad
            $error("asu_baud_gen: prescale out of range");
        end
    endgenerate

    logic [7:0] f8_cnt_r;
    logic [7:0] f32_cnt_r;
    logic [7:0] div_r;
    logic tick_r;
    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_last_r;
    logic fc_meta_r;
    logic fc_sync_r;
    logic fc_last_r;
    wire f8_tick = (f8_cnt_r == 8'(F8_DIV - 1));
    wire f32_tick = (f32_cnt_r == 8'(F32_DIV - 1));
    wire fc_tick = fc_sync_r & ~fc_last_r;
    // Pin clock counts only when routed and chosen
    wire ext_tick = ext_sync_r & ~ext_last_r & clock_pin_route_in;
    wire int_tick = (count_source_field_in == asu_pkg::SRC_F1) ? 1'b1 :
                    (count_source_field_in == asu_pkg::SRC_F8) ? f8_tick :
                    (count_source_field_in == asu_pkg::SRC_F32) ? f32_tick :
                    fc_tick;
    wire count_tick = clock_source_select_in ? ext_tick : int_tick;
    // A divider lowered mid-count wraps at once instead of rolling over
    wire div_wrap = count_tick && (div_r >= baud_divider_in);

    always_ff @(posedge clk_in) begin
        ext_meta_r <= ext_clock_pin_in;
        ext_sync_r <= ext_meta_r;
        fc_meta_r <= fc_clock_in;
        fc_sync_r <= fc_meta_r;
        ext_last_r <= ext_sync_r;
        fc_last_r <= fc_sync_r;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            f8_cnt_r <= 8'h00;
            f32_cnt_r <= 8'h00;
        end else begin
            f8_cnt_r <= f8_tick ? 8'h00 : f8_cnt_r + 8'h01;
            f32_cnt_r <= f32_tick ? 8'h00 : f32_cnt_r + 8'h01;
        end
    end

    // Divide by n+1 to give the x16 rate
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_r <= asu_pkg::DIV_RST;
            tick_r <= 1'b0;
        end else begin
            tick_r <= div_wrap;
            if (div_wrap) begin
                div_r <= 8'h00;
            end else if (count_tick) begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    assign tick16_out = tick_r;
endmodule // asu_baud_gen

// >>> src/asu_pkg.sv
// Overview of operation
// - Mode field 100b, 101b, 110b selects UART with 7, 8, 9 data bits.
// - Character data uses buffer bits b0..b6, b0..b7 or b0..b8 by length.
// - Unused receive buffer bits above the character length are undefined.
// - After an overrun the received data bits are undefined.
// - Bit rate is count source divided by divider register value plus 1, then by 16.
// - Internal count source field picks f1, f8, f32 or fC.
// - Clock source select picks internal prescaled clock or external clock pin.
// - Clock pin is used only with its route at 1 and external source chosen.
// - Bit order select applies to 8-bit frames only; else software keeps it 0.
// - Transmit pin idles high once UART is selected; open-drain idles released.
// - Output mode bit selects push-pull or N-channel open-drain transmit pin.
// - Transmit and receive run only while their enable bits are 1; a transmit frame already under way still finishes after its enable drops.
// - Buffer-empty, receive-complete, overrun and parity error flags are provided.
// - Shifter-empty flag shows no character left in the transmit shifter.
// - Transmit interrupt source select picks the transmit event raising the request.
// - Transmit route at 0 releases the transmit pin, allowing receive-only use.
// - Divider divides its count source by n+1, n from 00h to FFh.
// - Transmit interrupt on buffer load or shift end; receive interrupt on buffer fill.
// - Parity error when ones over data and parity mismatch odd or even choice.
package asu_pkg;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_UART7 = 3'h4;
    localparam logic [2:0] MODE_UART8 = 3'h5;
    localparam logic [2:0] MODE_UART9 = 3'h6;
    localparam logic [1:0] SRC_F1 = 2'h0;
    localparam logic [1:0] SRC_F8 = 2'h1;
    localparam logic [1:0] SRC_F32 = 2'h2;
    localparam logic [1:0] SRC_FC = 2'h3;
    localparam int PRESCALE_F8 = 8;
    localparam int PRESCALE_F32 = 32;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] START_MID = 4'h7;
    localparam logic [3:0] LEN7 = 4'h7;
    localparam logic [3:0] LEN8 = 4'h8;
    localparam logic [3:0] LEN9 = 4'h9;
    localparam int FRAME_W = 13;
    localparam int RX_W = 11;
    localparam logic [3:0] RX_W_CNT = 4'hb;
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [8:0] DATA_RST = 9'h000;
    localparam logic [7:0] DIV_RST = 8'h00;
    typedef enum logic [1:0] {ASU_RX_IDLE, ASU_RX_START, ASU_RX_BITS} asu_rx_state_type;
    typedef enum logic {ASU_TX_IDLE, ASU_TX_SHIFT} asu_tx_state_type;
endpackage

// >>> src/asu_uart.sv
`timescale 1ns/1ps
module asu_uart (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Mode and format
    input wire logic [2:0] serial_mode_field_in,
    input wire logic stop_length_select_in,
    input wire logic parity_odd_even_in,
    input wire logic parity_enable_in,
    input wire logic bit_order_select_in,
    // Clocking
    input wire logic clock_source_select_in,
    input wire logic [1:0] count_source_field_in,
    input wire logic [7:0] baud_divider_in,
    input wire logic fc_clock_in,
    // Control
    input wire logic tx_enable_in,
    input wire logic rx_enable_in,
    input wire logic tx_irq_source_select_in,
    input wire logic open_drain_select_in,
    // Pin routing
    input wire logic tx_pin_route_in,
    input wire logic rx_pin_route_in,
    input wire logic clock_pin_route_in,
    // Transmit buffer
    input wire logic [8:0] tx_data_in,
    input wire logic tx_write_in,
    output logic tx_buffer_empty_out,
    output logic shifter_empty_flag_out,
    output logic tx_irq_out,
    // Receive buffer
    input wire logic rx_read_in,
    output logic [8:0] rx_data_out,
    output logic rx_complete_out,
    output logic overrun_flag_out,
    output logic parity_fault_flag_out,
    output logic rx_irq_out,
    // Pins
    input wire logic serial_in_pin_in,
    input wire logic ext_clock_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out
);
    function automatic logic [3:0] asu_char_len(input logic [2:0] mode);
        case (mode)
            asu_pkg::MODE_UART7: asu_char_len = asu_pkg::LEN7;
            asu_pkg::MODE_UART8: asu_char_len = asu_pkg::LEN8;
            default: asu_char_len = asu_pkg::LEN9;
        endcase
    endfunction

    function automatic logic [7:0] asu_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    logic tick16;
    asu_pkg::asu_tx_state_type tx_state_r;
    asu_pkg::asu_rx_state_type rx_state_r;
    logic [8:0] tx_buf_r;
    logic tx_empty_r;
    logic [asu_pkg::FRAME_W-1:0] tx_shift_r;
    logic [3:0] tx_left_r;
    logic [3:0] tx_sub_r;
    logic tx_irq_r;
    logic rx_meta_r;
    logic rx_sync_r;
    logic [3:0] rx_sub_r;
    logic [3:0] rx_cnt_r;
    logic [asu_pkg::RX_W-1:0] rx_shift_r;
    logic [8:0] rx_data_r;
    logic rx_done_r;
    logic rx_ovr_r;
    logic rx_par_r;
    logic rx_irq_r;

    asu_baud_gen u_baud (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clock_source_select_in(clock_source_select_in),
        .clock_pin_route_in(clock_pin_route_in),
        .count_source_field_in(count_source_field_in),
        .baud_divider_in(baud_divider_in),
        .ext_clock_pin_in(ext_clock_pin_in),
        .fc_clock_in(fc_clock_in),
        .tick16_out(tick16)
    );

    // Mode decode and character shape
    wire uart_mode = (serial_mode_field_in == asu_pkg::MODE_UART7) ||
                     (serial_mode_field_in == asu_pkg::MODE_UART8) ||
                     (serial_mode_field_in == asu_pkg::MODE_UART9);
    wire [3:0] char_len = asu_char_len(serial_mode_field_in);
    wire [8:0] char_mask = 9'h1ff >> (4'h9 - char_len);
    // Reversal honoured only for 8-bit frames
    wire msb_first = bit_order_select_in && (char_len == asu_pkg::LEN8);
    wire [3:0] par_len = {3'h0, parity_enable_in};
    wire [3:0] stop_len = {3'h0, stop_length_select_in};

    // Transmit frame assembly
    wire [8:0] tx_masked = tx_buf_r & char_mask;
    wire [8:0] tx_ordered = msb_first ? {1'b0, asu_rev8(tx_masked[7:0])} :
                            tx_masked;
    wire tx_par = (^tx_masked) ^ ~parity_odd_even_in;
    // Ones above the data also form the stop bits
    wire [asu_pkg::FRAME_W-1:0] tx_ones = 13'h1fff << (char_len + 4'h1 + par_len);
    wire [asu_pkg::FRAME_W-1:0] tx_par_v = parity_enable_in ?
                                           (13'h0001 << (char_len + 4'h1)) & {13{tx_par}} :
                                           13'h0000;
    wire [asu_pkg::FRAME_W-1:0] tx_frame = tx_ones | tx_par_v | {3'h0, tx_ordered, 1'b0};
    wire [3:0] tx_len = 4'h2 + char_len + par_len + stop_len;

    // A write in the same cycle holds the load back, so the waiting character is overwritten
    wire tx_start = (tx_state_r == asu_pkg::ASU_TX_IDLE) && uart_mode && tx_enable_in &&
                    !tx_empty_r && !tx_write_in;
    wire tx_bit_end = (tx_state_r == asu_pkg::ASU_TX_SHIFT) && tick16 &&
                      (tx_sub_r == asu_pkg::OVS_LAST);
    wire tx_finish = tx_bit_end && (tx_left_r == 4'h0);
    wire tx_level = (tx_state_r == asu_pkg::ASU_TX_SHIFT) ? tx_shift_r[0] :
                    asu_pkg::PIN_IDLE;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_buf_r <= asu_pkg::DATA_RST;
            tx_empty_r <= asu_pkg::TX_EMPTY_RST;
        end else begin
            if (tx_write_in) begin
                tx_buf_r <= tx_data_in;
                tx_empty_r <= 1'b0;
            end else if (tx_start) begin
                tx_empty_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_state_r <= asu_pkg::ASU_TX_IDLE;
            tx_shift_r <= '1;
            tx_left_r <= 4'h0;
            tx_sub_r <= 4'h0;
        end else if (!uart_mode) begin
            tx_state_r <= asu_pkg::ASU_TX_IDLE;
            tx_sub_r <= 4'h0;
        end else begin
            case (tx_state_r)
                asu_pkg::ASU_TX_IDLE: begin
                    if (tx_start) begin
                        tx_state_r <= asu_pkg::ASU_TX_SHIFT;
                        tx_shift_r <= tx_frame;
                        tx_left_r <= tx_len - 4'h1;
                        tx_sub_r <= 4'h0;
                    end
                end
                asu_pkg::ASU_TX_SHIFT: begin
                    if (tick16) begin
                        tx_sub_r <= tx_sub_r + 4'h1;
                    end
                    if (tx_finish) begin
                        tx_state_r <= asu_pkg::ASU_TX_IDLE;
                    end else if (tx_bit_end) begin
                        tx_shift_r <= {1'b1, tx_shift_r[asu_pkg::FRAME_W-1:1]};
                        tx_left_r <= tx_left_r - 4'h1;
                    end
                end
                default: tx_state_r <= asu_pkg::ASU_TX_IDLE;
            endcase
        end
    end

    // Interrupt on load or on the end of the last stop bit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_irq_r <= 1'b0;
        end else begin
            tx_irq_r <= tx_irq_source_select_in ? tx_finish : tx_start;
        end
    end

    assign tx_buffer_empty_out = tx_empty_r;
    assign shifter_empty_flag_out = (tx_state_r == asu_pkg::ASU_TX_IDLE);
    assign tx_irq_out = tx_irq_r;
    // Open drain never drives high; released means idle high on the wire
    assign serial_out_pin_out = open_drain_select_in ? 1'b0 : tx_level;
    assign serial_out_pin_oe_out = tx_pin_route_in && uart_mode &&
                                   (!open_drain_select_in || !tx_level);

    // Receive line synchroniser
    always_ff @(posedge clk_in) begin
        rx_meta_r <= serial_in_pin_in;
        rx_sync_r <= rx_meta_r;
    end

    // Unrouted input reads as an idle line
    wire rx_line = rx_pin_route_in ? rx_sync_r : 1'b1;
    // Only the first stop bit is sampled
    wire [3:0] rx_len = char_len + par_len + 4'h1;
    wire rx_bit_end = (rx_state_r == asu_pkg::ASU_RX_BITS) && tick16 &&
                      (rx_sub_r == asu_pkg::OVS_LAST);
    wire rx_finish = rx_bit_end && (rx_cnt_r == rx_len - 4'h1);
    wire [asu_pkg::RX_W-1:0] rx_full = {rx_line, rx_shift_r[asu_pkg::RX_W-1:1]};
    wire [asu_pkg::RX_W-1:0] rx_aligned = rx_full >> (asu_pkg::RX_W_CNT - rx_len);
    wire [8:0] rx_masked = rx_aligned[8:0] & char_mask;
    wire rx_par_bit = rx_aligned[char_len];
    wire rx_par_err = parity_enable_in &&
                      ((^rx_masked) ^ rx_par_bit ^ ~parity_odd_even_in);
    wire [8:0] rx_ordered = msb_first ? {1'b0, asu_rev8(rx_masked[7:0])} :
                            rx_masked;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_state_r <= asu_pkg::ASU_RX_IDLE;
            rx_sub_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_shift_r <= '0;
        end else if (!uart_mode || !rx_enable_in) begin
            rx_state_r <= asu_pkg::ASU_RX_IDLE;
            rx_sub_r <= 4'h0;
        end else begin
            case (rx_state_r)
                asu_pkg::ASU_RX_IDLE: begin
                    if (!rx_line) begin
                        rx_state_r <= asu_pkg::ASU_RX_START;
                        rx_sub_r <= 4'h0;
                    end
                end
                asu_pkg::ASU_RX_START: begin
                    if (tick16 && rx_sub_r == asu_pkg::START_MID) begin
                        // A glitch shorter than half a bit is dropped
                        rx_state_r <= rx_line ? asu_pkg::ASU_RX_IDLE :
                                      asu_pkg::ASU_RX_BITS;
                        rx_sub_r <= 4'h0;
                        rx_cnt_r <= 4'h0;
                    end else if (tick16) begin
                        rx_sub_r <= rx_sub_r + 4'h1;
                    end
                end
                asu_pkg::ASU_RX_BITS: begin
                    if (tick16) begin
                        rx_sub_r <= rx_sub_r + 4'h1;
                    end
                    if (rx_bit_end) begin
                        rx_shift_r <= rx_full;
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_finish) begin
                            rx_state_r <= asu_pkg::ASU_RX_IDLE;
                        end
                    end
                end
                default: rx_state_r <= asu_pkg::ASU_RX_IDLE;
            endcase
        end
    end

    // New data wins over a read in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_data_r <= asu_pkg::DATA_RST;
            rx_done_r <= 1'b0;
            rx_ovr_r <= 1'b0;
            rx_par_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end else begin
            rx_irq_r <= rx_finish;
            if (rx_finish) begin
                // Overwritten on overrun; old contents are not kept
                rx_data_r <= rx_ordered;
                rx_done_r <= 1'b1;
                rx_par_r <= rx_par_err;
                if (rx_done_r && !rx_read_in) begin
                    rx_ovr_r <= 1'b1;
                end
            end else if (rx_read_in) begin
                rx_done_r <= 1'b0;
                rx_par_r <= 1'b0;
            end
            if (!uart_mode && !rx_finish) begin
                rx_ovr_r <= 1'b0;
            end
        end
    end

    assign rx_data_out = rx_data_r;
    assign rx_complete_out = rx_done_r;
    assign overrun_flag_out = rx_ovr_r;
    assign parity_fault_flag_out = rx_par_r;
    assign rx_irq_out = rx_irq_r;
endmodule // asu_uart
